// >>> src/smvr_regs.sv
// simd register state: vector, packed integer, general registers and csr
`timescale 1ns/1ps
`include "smvr_map.svh"
module smvr_regs
#(
    parameter int VEC_N = `SMVR_VEC_N
) (
    // clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   rst,
    // ahb-lite slave
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic      [31:0]            hrdata,
    // wide vector register ports
    input  wire smvr_pkg::smvr_sel_s    vec_rd_a,
    output logic [`SMVR_VEC_W-1:0]      vec_rd_a_data,
    input  wire smvr_pkg::smvr_sel_s    vec_rd_b,
    output logic [`SMVR_VEC_W-1:0]      vec_rd_b_data,
    input  wire smvr_pkg::smvr_vwr_s    vec_wr,
    // element view of vector read port a
    input  wire smvr_pkg::smvr_esel_s   elem_sel,
    output logic [`SMVR_QW-1:0]         elem_data,
    output logic [`SMVR_QW-1:0]         scalar_lo_data,
    // packed integer register ports
    input  wire logic [`SMVR_IDX_W-1:0] pint_rd_a_idx,
    output logic [`SMVR_QW-1:0]         pint_rd_a_data,
    input  wire logic [`SMVR_IDX_W-1:0] pint_rd_b_idx,
    output logic [`SMVR_QW-1:0]         pint_rd_b_data,
    input  wire logic [`SMVR_IDX_W-1:0] pint_mix_idx,
    output logic [`SMVR_QW-1:0]         pint_mix_data,
    input  wire smvr_pkg::smvr_qwr_s    pint_wr,
    // general-purpose register ports
    input  wire logic [`SMVR_IDX_W-1:0] gpr_rd_idx,
    input  wire logic                   gpr_rd_wide,
    output logic [`SMVR_QW-1:0]         gpr_rd_data,
    input  wire logic [`SMVR_IDX_W-1:0] addr_base_idx,
    output logic [`SMVR_QW-1:0]         addr_base_data,
    input  wire smvr_pkg::smvr_qwr_s    gpr_wr,
    // control/status, flags and feature query
    input  wire logic                   csr_wr_en,
    input  wire logic [`SMVR_DW-1:0]    csr_wr_data,
    input  wire logic [`SMVR_EXC_W-1:0] exc_set,
    output logic [`SMVR_DW-1:0]         csr_value,
    output logic                        daz_en,
    output logic                        ftz_en,
    input  wire smvr_pkg::smvr_cmp_s    cmp_wr,
    output logic [`SMVR_DW-1:0]         flags_value,
    input  wire logic                   feat_req,
    input  wire logic [`SMVR_DW-1:0]    feat_leaf,
    output logic [`SMVR_DW-1:0]         feat_result,
    // execution mode seen by the pipeline
    output smvr_pkg::smvr_mode_e        exec_mode
);

    import smvr_pkg::*;

    // ------------------------------------------------------------------
    // execution mode and index forming
    // ------------------------------------------------------------------
    smvr_mode_e              mode;
    logic                    ext_ok;
    logic [`SMVR_VIDX_W-1:0] vidx_w;
    logic [`SMVR_VEC_W-1:0]  vec_mask;

    // no mode gates the registers off; only the upper eight and the gpr access width depend on mode
    assign exec_mode = mode; // RULE14
    assign ext_ok    = (mode == SMVR_MODE_LONG); // RULE11

    // an extension bit outside 64-bit mode is dropped, never faulted
    function automatic logic [`SMVR_VIDX_W-1:0] vsel(input smvr_sel_s s,
                                                     input logic en);
        vsel = {s.ext & en, s.idx}; // RULE10 RULE13
    endfunction : vsel

    assign vidx_w   = vsel(vec_wr.sel, ext_ok);
    // scalar writes leave the high quadword untouched
    assign vec_mask = (vec_wr.mode == SMVR_WR_SCALAR)
                    ? {{`SMVR_QW{1'b0}}, {`SMVR_QW{1'b1}}} // RULE3
                    : {`SMVR_VEC_W{1'b1}};

    // ------------------------------------------------------------------
    // wide vector registers and element view
    // ------------------------------------------------------------------
    // sixteen entries; compat and legacy modes only ever reach 0..7
    smvr_bank #(
        .N  (VEC_N),
        .W  (`SMVR_VEC_W),
        .AW (`SMVR_VIDX_W)
    ) u_vec (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .rd_a_idx  (vsel(vec_rd_a, ext_ok)),
        .rd_a_data (vec_rd_a_data),
        .rd_b_idx  (vsel(vec_rd_b, ext_ok)),
        .rd_b_data (vec_rd_b_data),
        .rd_c_idx  (vidx_w),
        .rd_c_data (),
        .wr_en     (vec_wr.en),
        .wr_idx    (vidx_w),
        .wr_mask   (vec_mask),
        .wr_data   (vec_wr.data)
    ); // RULE2 RULE17

    logic [6:0]             elem_off;
    logic [`SMVR_VEC_W-1:0] elem_shift;
    logic [`SMVR_QW-1:0]    next_elem;
    always_comb
    begin
        case (elem_sel.size)
            SMVR_EL_BYTE:  elem_off = {elem_sel.index, 3'h0};
            SMVR_EL_WORD:  elem_off = {elem_sel.index[2:0], 4'h0};
            SMVR_EL_DWORD: elem_off = {elem_sel.index[1:0], 5'h00};
            SMVR_EL_QWORD: elem_off = {elem_sel.index[0], 6'h00};
            default:       elem_off = 7'h00;
        endcase
        elem_shift = vec_rd_a_data >> elem_off;
        case (elem_sel.size)
            SMVR_EL_BYTE:  next_elem = {56'h0, elem_shift[7:0]}; // RULE4
            SMVR_EL_WORD:  next_elem = {48'h0, elem_shift[15:0]};
            SMVR_EL_DWORD: next_elem = {32'h0, elem_shift[31:0]};
            SMVR_EL_QWORD: next_elem = elem_shift[`SMVR_QW-1:0];
            default:       next_elem = '0;
        endcase
    end

    // element and scalar views are registered, one cycle behind the select
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            elem_data      <= '0;
            scalar_lo_data <= '0;
        end
        else
        begin
            elem_data      <= next_elem;
            scalar_lo_data <= vec_rd_a_data[`SMVR_QW-1:0]; // RULE3
        end
    end

    // ------------------------------------------------------------------
    // packed integer and general-purpose registers
    // ------------------------------------------------------------------
    smvr_bank #(
        .N  (`SMVR_BASE_N),
        .W  (`SMVR_QW),
        .AW (`SMVR_IDX_W)
    ) u_pint (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .rd_a_idx  (pint_rd_a_idx),
        .rd_a_data (pint_rd_a_data),
        .rd_b_idx  (pint_rd_b_idx),
        .rd_b_data (pint_rd_b_data),
        .rd_c_idx  (pint_mix_idx),
        .rd_c_data (pint_mix_data),
        .wr_en     (pint_wr.en),
        .wr_idx    (pint_wr.idx),
        .wr_mask   ({`SMVR_QW{1'b1}}),
        .wr_data   (pint_wr.data)
    ); // RULE6

    logic [`SMVR_QW-1:0] gpr_raw;
    logic [`SMVR_QW-1:0] gpr_wdata;
    logic                gpr_wr_wide;
    logic                gpr_rd_full;

    // width bit only has meaning in 64-bit mode; elsewhere it is ignored
    assign gpr_wr_wide = gpr_wr.wide & ext_ok; // RULE12 RULE13
    assign gpr_rd_full = gpr_rd_wide & ext_ok; // RULE12
    // narrow writes clear the upper half, as a 32-bit result does
    assign gpr_wdata   = gpr_wr_wide ? gpr_wr.data
                                     : {32'h0, gpr_wr.data[`SMVR_DW-1:0]};
    assign gpr_rd_data = gpr_rd_full ? gpr_raw
                                     : {32'h0, gpr_raw[`SMVR_DW-1:0]};

    // the address port is wired only to this bank, nothing else feeds it
    smvr_bank #(
        .N  (`SMVR_BASE_N),
        .W  (`SMVR_QW),
        .AW (`SMVR_IDX_W)
    ) u_gpr (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .rd_a_idx  (gpr_rd_idx),
        .rd_a_data (gpr_raw),
        .rd_b_idx  (addr_base_idx),
        .rd_b_data (addr_base_data),
        .rd_c_idx  (gpr_wr.idx),
        .rd_c_data (),
        .wr_en     (gpr_wr.en),
        .wr_idx    (gpr_wr.idx),
        .wr_mask   ({`SMVR_QW{1'b1}}),
        .wr_data   (gpr_wdata)
    ); // RULE7 RULE8

    // ------------------------------------------------------------------
    // ahb-lite address and data phase
    // ------------------------------------------------------------------
    logic       acc;
    logic       dp_wr;
    logic [7:0] dp_addr;
    logic       bus_csr_wr;
    logic       bus_mode_wr;

    // zero wait states; every answer is okay
    assign hreadyout   = 1'b1;
    assign hresp       = `SMVR_HRESP_OKAY;
    assign acc         = hsel & hready & htrans[1];
    assign bus_csr_wr  = dp_wr & (dp_addr == `SMVR_OFS_CSR);
    assign bus_mode_wr = dp_wr & (dp_addr == `SMVR_OFS_MODE);

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            dp_wr   <= 1'b0;
            dp_addr <= 8'h00;
        end
        else
        begin
            dp_wr   <= acc & hwrite;
            dp_addr <= haddr[7:0];
        end
    end

    // ------------------------------------------------------------------
    // control/status and mode registers
    // ------------------------------------------------------------------
    logic [`SMVR_DW-1:0] csr;
    logic [`SMVR_DW-1:0] next_csr;

    always_comb
    begin
        next_csr = csr;
        if (bus_csr_wr)
            next_csr = hwdata & `SMVR_CSR_WMASK;
        else if (csr_wr_en)
            next_csr = csr_wr_data & `SMVR_CSR_WMASK;
        // sticky exception flags: a set in the clearing cycle survives
        next_csr[`SMVR_EXC_W-1:0] = next_csr[`SMVR_EXC_W-1:0] | exc_set;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            csr <= `SMVR_CSR_RESET;
        else
            csr <= next_csr; // RULE5 RULE15
    end

    assign csr_value = csr;
    assign daz_en    = csr[`SMVR_DAZ_BIT]; // RULE16
    assign ftz_en    = csr[`SMVR_FTZ_BIT]; // RULE5

    // undefined mode codes keep the current mode
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            mode <= SMVR_MODE_REAL;
        else if (bus_mode_wr && hwdata[2:0] <= 3'(SMVR_MODE_LONG))
            mode <= smvr_mode_e'(hwdata[2:0]);
    end

    // ------------------------------------------------------------------
    // condition flags, feature query and status
    // ------------------------------------------------------------------
    logic [`SMVR_DW-1:0] flags;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            flags <= '0;
        else if (cmp_wr.en)
        begin
            flags[`SMVR_FL_ZF] <= cmp_wr.zf; // RULE9
            flags[`SMVR_FL_PF] <= cmp_wr.pf;
            flags[`SMVR_FL_CF] <= cmp_wr.cf;
            flags[`SMVR_FL_OF] <= 1'b0;
            flags[`SMVR_FL_SF] <= 1'b0;
            flags[`SMVR_FL_AF] <= 1'b0;
        end
    end

    assign flags_value = flags;

    logic [`SMVR_DW-1:0] feat_word;
    assign feat_word = `SMVR_DW'(1) << `SMVR_FEAT_BIT; // RULE1

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            feat_result <= '0;
        else if (feat_req)
            feat_result <= (feat_leaf == `SMVR_FEAT_LEAF) ? feat_word : '0;
    end

    logic [`SMVR_VIDX_W-1:0] last_widx;
    logic [`SMVR_DW-1:0]     rd_mux;
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            last_widx <= '0;
        else if (vec_wr.en)
            last_widx <= vidx_w;
    end

    always_comb
    begin
        case (haddr[7:0])
            `SMVR_OFS_CSR:     rd_mux = csr;
            `SMVR_OFS_FEATURE: rd_mux = feat_word;
            `SMVR_OFS_MODE:    rd_mux = {29'h0, mode};
            `SMVR_OFS_FLAGS:   rd_mux = flags;
            `SMVR_OFS_STATUS:  rd_mux = {24'h0, last_widx, 3'h0, ext_ok};
            default:           rd_mux = '0;
        endcase
    end

    // read data is sampled in the address phase; unmapped reads give zero
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            hrdata <= '0;
        else if (acc & ~hwrite)
            hrdata <= rd_mux;
    end

endmodule : smvr_regs

// >>> pkg/smvr_map.svh
// constants, offsets and bit positions of the simd register state block
//
// Notes on behaviour
// RULE1 - feature query leaf 1 reports bit 26 of the result word set.
// RULE2 - eight 128-bit wide vector registers, indices zero to seven.
// RULE3 - scalar double writes and reads touch only the low quadword.
// RULE4 - wide registers read as two doubles or packed bytes to quadwords.
// RULE5 - 32-bit control/status register with denormal and flush-to-zero flags.
// RULE6 - eight 64-bit packed integer registers, also usable beside wide ones.
// RULE7 - memory addresses come only from general-purpose registers.
// RULE8 - eight general-purpose registers serve addressing and simd operands.
// RULE9 - some compares write their outcome into the 32-bit flags register.
// RULE10 - in 64-bit mode the extension prefix bit reaches wide registers 8-15.
// RULE11 - compatibility mode behaves like protected mode, eight wide registers.
// RULE12 - width prefix bit selects full 64-bit general-purpose register access.
// RULE13 - a prefix without meaning is ignored silently, with no fault.
// RULE14 - the registers are usable in every execution mode.
// RULE15 - no state beyond the wide registers and control/status register.
// RULE16 - denormals-as-zero is bit 6 of the control/status register.
// RULE17 - two vector reads and one write per cycle, write seen next cycle.
`ifndef SMVR_MAP_SVH
`define SMVR_MAP_SVH

// ----------------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------------
`define SMVR_VEC_W        128
`define SMVR_QW           64
`define SMVR_DW           32
`define SMVR_IDX_W        3
`define SMVR_VIDX_W       4
`define SMVR_VEC_N        16
`define SMVR_BASE_N       8
`define SMVR_EXC_W        6

// ----------------------------------------------------------------------
// feature query and control/status register
// ----------------------------------------------------------------------
`define SMVR_FEAT_LEAF    32'h0000_0001
`define SMVR_FEAT_BIT     26
`define SMVR_DAZ_BIT      6
`define SMVR_FTZ_BIT      15
`define SMVR_CSR_RESET    32'h0000_0000
`define SMVR_CSR_WMASK    32'h0000_ffff

// ----------------------------------------------------------------------
// condition flag positions
// ----------------------------------------------------------------------
`define SMVR_FL_CF        0
`define SMVR_FL_PF        2
`define SMVR_FL_AF        4
`define SMVR_FL_ZF        6
`define SMVR_FL_SF        7
`define SMVR_FL_OF        11

// ----------------------------------------------------------------------
// bus register map (byte offsets) and protocol codes
// ----------------------------------------------------------------------
`define SMVR_OFS_CSR      8'h00
`define SMVR_OFS_FEATURE  8'h04
`define SMVR_OFS_MODE     8'h08
`define SMVR_OFS_FLAGS    8'h0c
`define SMVR_OFS_STATUS   8'h10
`define SMVR_HRESP_OKAY   1'b0
`define SMVR_STAT_IDX_LSB 4

`endif

// >>> pkg/smvr_pkg.sv
// types shared by the simd register state block
`include "smvr_map.svh"
package smvr_pkg;

    typedef enum logic [2:0] {
        SMVR_MODE_REAL,
        SMVR_MODE_PROT,
        SMVR_MODE_V86,
        SMVR_MODE_COMPAT,
        SMVR_MODE_LONG
    } smvr_mode_e;

    typedef enum logic {
        SMVR_WR_FULL,
        SMVR_WR_SCALAR
    } smvr_wmode_e;

    typedef enum logic [1:0] {
        SMVR_EL_BYTE,
        SMVR_EL_WORD,
        SMVR_EL_DWORD,
        SMVR_EL_QWORD
    } smvr_elem_e;

    // register select with the extension prefix bit beside it
    typedef struct packed {
        logic                   ext;
        logic [`SMVR_IDX_W-1:0] idx;
    } smvr_sel_s;

    typedef struct packed {
        logic                   en;
        smvr_sel_s              sel;
        smvr_wmode_e            mode;
        logic [`SMVR_VEC_W-1:0] data;
    } smvr_vwr_s;

    typedef struct packed {
        logic                   en;
        logic                   wide;
        logic [`SMVR_IDX_W-1:0] idx;
        logic [`SMVR_QW-1:0]    data;
    } smvr_qwr_s;

    typedef struct packed {
        logic                   en;
        logic                   zf;
        logic                   pf;
        logic                   cf;
    } smvr_cmp_s;

    typedef struct packed {
        smvr_elem_e             size;
        logic [3:0]             index;
    } smvr_esel_s;

endpackage : smvr_pkg

// >>> src/smvr_bank.sv
// register bank: three read ports, one masked write port
`timescale 1ns/1ps
module smvr_bank #(
    parameter int N  = 8,
    parameter int W  = 64,
    parameter int AW = 3
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst,
    // read ports
    input  wire logic [AW-1:0] rd_a_idx,
    output logic      [W-1:0]  rd_a_data,
    input  wire logic [AW-1:0] rd_b_idx,
    output logic      [W-1:0]  rd_b_data,
    input  wire logic [AW-1:0] rd_c_idx,
    output logic      [W-1:0]  rd_c_data,
    // write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic [W-1:0]  wr_mask,
    input  wire logic [W-1:0]  wr_data
);

    logic [W-1:0] mem [N];

    // reads come straight off the array, so a write lands for the next cycle
    assign rd_a_data = mem[rd_a_idx];
    assign rd_b_data = mem[rd_b_idx];
    assign rd_c_data = mem[rd_c_idx];

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < N; i++)
                mem[i] <= '0;
        end
        else if (wr_en)
        begin
            mem[wr_idx] <= (mem[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
        end
    end

endmodule : smvr_bank

// >>> tb/smvr_regs_assertions.sv
// assertions on the simd register state ports
`timescale 1ns/1ps
module smvr_regs_assertions (
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 rst,
    // vector ports
    input wire smvr_pkg::smvr_sel_s  vec_rd_a,
    input wire smvr_pkg::smvr_sel_s  vec_rd_b,
    input wire smvr_pkg::smvr_vwr_s  vec_wr,
    input wire logic [127:0]         vec_rd_a_data,
    input wire logic [127:0]         vec_rd_b_data,
    // scalar state
    input wire logic                 gpr_rd_wide,
    input wire logic [63:0]          gpr_rd_data,
    input wire logic [31:0]          csr_value,
    input wire logic                 daz_en,
    input wire logic [5:0]           exc_set,
    input wire smvr_pkg::smvr_cmp_s  cmp_wr,
    input wire logic [31:0]          flags_value,
    input wire logic                 feat_req,
    input wire logic [31:0]          feat_leaf,
    input wire logic [31:0]          feat_result,
    input wire smvr_pkg::smvr_mode_e exec_mode
);
    import smvr_pkg::*;
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    property p_feat;
        feat_req && feat_leaf == 32'h1 |=> feat_result == 32'h0400_0000;
    endproperty
    a_feat: assert property (p_feat) else $error("feature bit");
    property p_wr;
        vec_wr.en && vec_wr.mode == SMVR_WR_FULL &&
        exec_mode == SMVR_MODE_LONG ##1 vec_rd_a == $past(vec_wr.sel)
        && $stable(exec_mode)
        |-> vec_rd_a_data == $past(vec_wr.data);
    endproperty
    a_wr: assert property (p_wr) else $error("write not seen");
    property p_sc;
        vec_wr.en && vec_wr.mode == SMVR_WR_SCALAR && vec_rd_a == vec_wr.sel
        && exec_mode == SMVR_MODE_LONG ##1 $stable(vec_rd_a)
        && $stable(exec_mode) |-> vec_rd_a_data ==
        {$past(vec_rd_a_data[127:64]), $past(vec_wr.data[63:0])};
    endproperty
    a_sc: assert property (p_sc) else $error("scalar write");
    property p_al;
        exec_mode != SMVR_MODE_LONG && vec_rd_a.ext && !vec_rd_b.ext &&
        vec_rd_b.idx == vec_rd_a.idx |-> vec_rd_a_data == vec_rd_b_data;
    endproperty
    a_al: assert property (p_al) else $error("upper bank seen");
    property p_gw;
        !(gpr_rd_wide && exec_mode == SMVR_MODE_LONG)
        |-> gpr_rd_data[63:32] == 32'h0;
    endproperty
    a_gw: assert property (p_gw) else $error("gpr width");
    property p_cmp;
        cmp_wr.en |=> {flags_value[6], flags_value[4], flags_value[2],
        flags_value[0]} == {$past(cmp_wr.zf), 1'b0, $past(cmp_wr.pf),
        $past(cmp_wr.cf)};
    endproperty
    a_cmp: assert property (p_cmp) else $error("flags");
    property p_exc;
        exc_set != 6'h0 |=> (csr_value[5:0] & $past(exc_set)) ==
        $past(exc_set);
    endproperty
    a_exc: assert property (p_exc) else $error("sticky flag");
    property p_daz;
        daz_en == csr_value[6];
    endproperty
    a_daz: assert property (p_daz) else $error("daz bit");
endmodule : smvr_regs_assertions

bind smvr_regs smvr_regs_assertions u_smvr_regs_assertions (
    .ref_clk, .rst, .vec_rd_a, .vec_rd_b, .vec_wr, .vec_rd_a_data,
    .vec_rd_b_data, .gpr_rd_wide, .gpr_rd_data, .csr_value, .daz_en,
    .exc_set, .cmp_wr, .flags_value, .feat_req, .feat_leaf,
    .feat_result, .exec_mode
);

// >>> tb/smvr_pipe_model.sv
// pipeline-side model driving the vector register ports
`timescale 1ns/1ps
module smvr_pipe_model (
    // clock
    input wire logic              ref_clk,
    // vector selects and write
    output smvr_pkg::smvr_sel_s   vec_rd_a,
    output smvr_pkg::smvr_sel_s   vec_rd_b,
    output smvr_pkg::smvr_vwr_s   vec_wr,
    output smvr_pkg::smvr_esel_s  elem_sel
);
    import smvr_pkg::*;
    initial
    begin
        vec_rd_a = '0;
        vec_rd_b = '0;
        vec_wr = '0;
        elem_sel = '0;
    end
    // released fields are scrambled so nothing leans on stale data
    task put(input logic [3:0] s, input smvr_wmode_e m,
             input logic [127:0] d);
        @(posedge ref_clk);
        vec_wr <= '{1'b1, s, m, d};
        @(posedge ref_clk);
        vec_wr <= '{1'b0, ~s, m, ~d};
    endtask : put
    task look(input logic [3:0] a, b, input smvr_esel_s e);
        @(posedge ref_clk);
        vec_rd_a <= a;
        vec_rd_b <= b;
        elem_sel <= e;
    endtask : look
endmodule : smvr_pipe_model

// >>> tb/smvr_regs_test.sv
// self-checking bench of the simd register state block
`timescale 1ns/1ps
module smvr_regs_test;
    import smvr_pkg::*;
    localparam logic [63:0] gval = 64'h8765_4321_0fed_cba9;
    localparam logic [63:0] pval = 64'h0f0f_1e1e_2d2d_3c3c;
    logic         ref_clk = 1'b0;
    logic         rst = 1'b1;
    logic [31:0]  haddr = 32'h0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [31:0]  hwdata = 32'h0;
    logic [31:0]  feat_leaf = 32'h0;
    logic [31:0]  hrdata, rd, csr_value, flags_value, feat_result;
    logic         hreadyout, hresp, daz_en, ftz_en, feat_req = 1'b0;
    logic [127:0] vec_rd_a_data, vec_rd_b_data, ex;
    logic [63:0]  elem_data, scalar_lo_data, pa, pb, pm, gd, ad;
    logic [2:0]   pidx = 3'h0, gidx = 3'h0;
    logic         gwide = 1'b0, cwe = 1'b0;
    logic [5:0]   exc_set = 6'h0;
    smvr_sel_s    vec_rd_a, vec_rd_b;
    smvr_vwr_s    vec_wr;
    smvr_esel_s   elem_sel;
    smvr_qwr_s    pint_wr = '0, gpr_wr = '0;
    smvr_cmp_s    cmp_wr = '0;
    smvr_mode_e   exec_mode;
    int           bad_count = 0, checks_done = 0;
    smvr_regs u_smvr_regs (
        .ref_clk, .rst, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .vec_rd_a, .vec_rd_a_data, .vec_rd_b, .vec_rd_b_data,
        .vec_wr, .elem_sel, .elem_data, .scalar_lo_data,
        .pint_rd_a_idx(pidx), .pint_rd_a_data(pa), .pint_rd_b_idx(pidx),
        .pint_rd_b_data(pb), .pint_mix_idx(pidx), .pint_mix_data(pm),
        .pint_wr, .gpr_rd_idx(gidx), .gpr_rd_wide(gwide),
        .gpr_rd_data(gd), .addr_base_idx(gidx), .addr_base_data(ad),
        .gpr_wr, .csr_wr_en(cwe), .csr_wr_data(32'h0001_0040), .exc_set,
        .csr_value, .daz_en, .ftz_en, .cmp_wr, .flags_value, .feat_req,
        .feat_leaf, .feat_result, .exec_mode
    );
    smvr_pipe_model u_smvr_pipe_model (
        .ref_clk, .vec_rd_a, .vec_rd_b, .vec_wr, .elem_sel
    );
    always #5 ref_clk = ~ref_clk;
    function automatic logic [127:0] vpat(input logic [3:0] n);
        return {8{n, 12'ha5c}};
    endfunction : vpat
    task chk(input string n, input logic [127:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task step;
        @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : step
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 99);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 99);
        rd = hrdata;
        if (n >= 99)
            bad_count++;
    endtask : ahb
    task print_verdict;
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict
    initial
    begin
        #50000;
        bad_count++;
        print_verdict;
    end
    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        ahb(1'b0, 8'h04, 32'h0);
        chk("feature", rd, 32'h0400_0000);
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", {hresp, rd}, 33'h0);
        @(posedge ref_clk);
        feat_req <= 1'b1;
        feat_leaf <= 32'h1;
        step;
        chk("leaf one", feat_result, 32'h0400_0000);
        @(posedge ref_clk);
        feat_leaf <= 32'h2;
        step;
        chk("leaf two", feat_result, 32'h0);
        ahb(1'b1, 8'h00, 32'hffff_0040);
        ahb(1'b0, 8'h00, 32'h0);
        chk("csr", rd, 32'h40);
        @(posedge ref_clk);
        exc_set <= 6'h21;
        @(posedge ref_clk);
        exc_set <= 6'h0;
        step;
        chk("sticky", {daz_en, ftz_en, csr_value}, {2'b10, 32'h61});
        ahb(1'b1, 8'h00, 32'h8000);
        step;
        chk("ftz", {daz_en, ftz_en}, 2'b01);
        @(posedge ref_clk);
        cwe <= 1'b1;
        @(posedge ref_clk);
        cwe <= 1'b0;
        step;
        chk("pipe csr", csr_value, 32'h40);
        ahb(1'b1, 8'h08, 32'h4);
        u_smvr_pipe_model.look(4'hf, 4'h0, '0);
        for (int i = 0; i < 16; i++)
            u_smvr_pipe_model.put(4'(i), SMVR_WR_FULL, vpat(4'(i)));
        for (int i = 0; i < 16; i++)
        begin
            u_smvr_pipe_model.look(4'(i), 4'(15 - i), '0);
            step;
            chk("vec a", vec_rd_a_data, vpat(4'(i)));
            chk("vec b", vec_rd_b_data, vpat(4'(15 - i)));
        end
        for (int s = 0; s < 4; s++)
        begin
            u_smvr_pipe_model.look(4'h2, 4'h2, '{smvr_elem_e'(s), 4'h1});
            step;
            ex = vpat(4'h2) >> (8 << s);
            chk("elem", elem_data, ex & ((128'h1 << (8 << s)) - 1));
        end
        ex = vpat(4'h3);
        u_smvr_pipe_model.look(4'h3, 4'h3, '0);
        u_smvr_pipe_model.put(4'h3, SMVR_WR_SCALAR, ~ex);
        step;
        chk("scalar", vec_rd_a_data, {ex[127:64], ~ex[63:0]});
        chk("scalar lo", scalar_lo_data, {64'h0, ~ex[63:0]});
        for (int m = 0; m < 4; m++)
        begin
            ahb(1'b1, 8'h08, 32'(m));
            u_smvr_pipe_model.look(4'ha, 4'h2, '0);
            step;
            chk("alias", vec_rd_a_data, vpat(4'h2));
            chk("mode", exec_mode, m);
        end
        ahb(1'b1, 8'h08, 32'h4);
        @(posedge ref_clk);
        gpr_wr <= '{1'b1, 1'b1, 3'h5, gval};
        pint_wr <= '{1'b1, 1'b0, 3'h7, pval};
        gidx <= 3'h5;
        pidx <= 3'h7;
        @(posedge ref_clk);
        gpr_wr.en <= 1'b0;
        pint_wr.en <= 1'b0;
        step;
        chk("gpr narrow", gd, {32'h0, gval[31:0]});
        chk("addr base", ad, gval);
        chk("pint", {pa, pb, pm}, {pval, pval, pval});
        @(posedge ref_clk);
        gwide <= 1'b1;
        step;
        chk("gpr wide", gd, gval);
        @(posedge ref_clk);
        cmp_wr <= '{1'b1, 1'b1, 1'b0, 1'b1};
        @(posedge ref_clk);
        cmp_wr <= '0;
        ahb(1'b0, 8'h0c, 32'h0);
        chk("flags", {rd, flags_value}, {2{32'h41}});
        ahb(1'b0, 8'h10, 32'h0);
        chk("status", rd, 32'h31);
        print_verdict;
    end
endmodule : smvr_regs_test
